// ### core/vsf_pkg.sv
// Purpose: Constants and linear decode helper for the slew, scale and floor registers
// Assumes: Word reads and writes arrive already decoded from the host serial link
// Notes: Operation
// Operation
// - Code 27h holds output slew rate in mV/us, linear eleven-bit, word access.
// - Slew rate is not used for turn-on or turn-off ramps.
// - Slew exponent resets to 11100b (-4); one mantissa step is 0.0625 mV/us.
// - Any valid slew word reads back as written; hardware uses nearest supported rate.
// - Valid slew range is 0.067 to 15.933 mV/us; others are invalid data.
// - Out-of-range writes to the slew and scale registers flag invalid data and alert the host.
// - Code 29h reaches hardware at once only while conversion is off.
// - Scale factor maps command to control input and picks the feedback divider.
// - Divider is 0.125, 0.25, 0.5 or 1.0 by decoded scale thresholds.
// - Reference scaling uses the scale word as written, even unsupported values.
// - Code 2Bh holds an unsigned sixteen-bit absolute floor on the output target.
// - While converting, a target below the floor warns and ramps to the floor.
// - Floor warning sets status byte, status word and status vout bits, alerts host.
// - While converting, writing the floor above the present target gives the same warning response.
package vsf_pkg;

    // Command codes
    localparam logic [7:0] CMD_OUTPUT_SLEW_RATE = 8'h27;
    localparam logic [7:0] CMD_FEEDBACK_SCALE = 8'h29;
    localparam logic [7:0] CMD_OUTPUT_FLOOR = 8'h2b;

    // Linear eleven-bit field layout
    localparam int LIN_EXP_MSB = 15;
    localparam int LIN_EXP_LSB = 11;
    localparam int LIN_MANT_MSB = 10;

    // Reset values
    localparam logic [4:0] SLEW_EXP_RESET = 5'h1c;
    localparam logic [10:0] SLEW_MANT_RESET = 11'h010;
    localparam logic [4:0] SCALE_EXP_RESET = 5'h19;
    localparam logic [10:0] SCALE_MANT_RESET = 11'h080;
    localparam logic [15:0] FLOOR_RESET = 16'h0000;
    localparam logic [15:0] TARGET_RESET = 16'h0000;

    // Slew limits in uV/us, compared against a value with SLEW_CHECK_FRAC fraction bits
    localparam int SLEW_CHECK_FRAC = 10;
    localparam logic signed [47:0] SLEW_MIN_UV_PER_US = 48'sd67;
    localparam logic signed [47:0] SLEW_MAX_UV_PER_US = 48'sd15933;
    localparam logic signed [47:0] UV_PER_MV = 48'sd1000;
    localparam int SLEW_HW_FRAC = 4;
    localparam int SLEW_HW_W = 8;

    // Scale factor held with 16 fraction bits
    localparam int SCALE_FRAC = 16;
    localparam logic signed [47:0] SCALE_EIGHTH = 48'sh2000;
    localparam logic signed [47:0] SCALE_QUARTER = 48'sh4000;
    localparam logic signed [47:0] SCALE_HALF = 48'sh8000;
    localparam logic signed [47:0] SCALE_UNITY = 48'sh10000;

    // Output setpoint LSB in 1/16 mV (setpoint exponent -9 gives 1.953 mV)
    localparam int VOUT_LSB_SIXTEENTHS = 31;

    // Slew rate base interval
    localparam int CLK_PERIOD_NS = 10;
    localparam int SLEW_TICK_TIME_NS = 1000;
    localparam int SLEW_TICK_CYCLES = SLEW_TICK_TIME_NS / CLK_PERIOD_NS;
    localparam int TICK_CNT_W = 7;

    typedef enum logic [1:0] {DIV_EIGHTH, DIV_QUARTER, DIV_HALF, DIV_UNITY} vsf_div_t;

    // Decodes a linear eleven-bit word into fixed point with frac fraction bits
    function automatic logic signed [47:0] lin11_fixed(input logic [15:0] word, input int frac);
        logic signed [47:0] mant;
        int sh;
        mant = 48'(signed'(word[LIN_MANT_MSB:0]));
        sh = int'(signed'(word[LIN_EXP_MSB:LIN_EXP_LSB])) + frac;
        if (sh >= 0)
        begin
            return mant <<< sh;
        end
        return mant >>> (-sh);
    endfunction

endpackage

// ### core/vsf_ramp.sv
// Purpose: Moves the output setpoint toward its target at the programmed slew rate
// Assumes: tick pulses once per microsecond; slew given in 1/16 mV/us
// Notes: load_now jumps straight to target, used for turn-on and turn-off
`timescale 1ns/1ps
module vsf_ramp #(
    parameter int VOUT_W = 16,
    parameter int SLEW_W = 8,
    parameter int ACC_W = 12,
    parameter int LSB_SIXTEENTHS = 31
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Control
    input wire logic tick,
    input wire logic load_now,
    input wire logic [SLEW_W-1:0] slew,
    input wire logic [VOUT_W-1:0] target,
    // Setpoint
    output logic [VOUT_W-1:0] vout
);
    localparam logic [ACC_W-1:0] LSB_STEP = ACC_W'(LSB_SIXTEENTHS);

    logic [VOUT_W-1:0] vout_reg;
    logic [VOUT_W-1:0] vout_next;
    logic [ACC_W-1:0] acc_reg;
    logic [ACC_W-1:0] acc_next;

    always_comb
    begin
        vout_next = vout_reg;
        acc_next = acc_reg;
        if (load_now)
        begin
            vout_next = target;
            acc_next = '0;
        end
        else if (vout_reg == target)
        begin
            acc_next = '0;
        end
        else
        begin
            if (tick)
            begin
                acc_next = acc_reg + ACC_W'(slew);
            end
            if (acc_reg >= LSB_STEP)
            begin
                acc_next = acc_next - LSB_STEP;
                if (vout_reg < target)
                begin
                    vout_next = vout_reg + 1'b1;
                end
                else
                begin
                    vout_next = vout_reg - 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            vout_reg <= '0;
            acc_reg <= '0;
        end
        else
        begin
            vout_reg <= vout_next;
            acc_reg <= acc_next;
        end
    end

    assign vout = vout_reg;
endmodule

// ### core/vsf_regs.sv
// Purpose: Slew, scale and floor command registers with floor clamp and status
// Assumes: One word command per cmd_valid pulse; status clear comes from the host command decoder
// Notes: Invalid writes are not stored; host_alert_n stays low while any status flag is set
`timescale 1ns/1ps
module vsf_regs #(
    parameter logic [10:0] SLEW_MANT_INIT = vsf_pkg::SLEW_MANT_RESET,
    parameter logic [10:0] SCALE_MANT_INIT = vsf_pkg::SCALE_MANT_RESET,
    parameter logic [15:0] FLOOR_INIT = vsf_pkg::FLOOR_RESET
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Word command port
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    output logic rsp_refused,
    // Converter state
    input wire logic conversion_enable,
    input wire logic onoff_load,
    input wire logic user_restore,
    input wire logic analog_supply_input_uvlo,
    // Target requests from command, trim and margin
    input wire logic target_req_valid,
    input wire logic [15:0] target_req_value,
    // Status handling
    input wire logic clear_status,
    output logic status_byte_none_above,
    output logic status_word_vout,
    output logic status_vout_minmax_warn,
    output logic status_cml_invalid_data,
    output logic status_cml_invalid_cmd,
    output logic host_alert_n,
    // Hardware settings
    output logic [vsf_pkg::SLEW_HW_W-1:0] slew_applied,
    output logic [15:0] scale_applied,
    output vsf_pkg::vsf_div_t divider_sel,
    output logic [15:0] vout_target,
    output logic [15:0] vout_setpoint
);
    import vsf_pkg::*;

    logic [15:0] slew_reg, slew_next;
    logic [SLEW_HW_W-1:0] slew_hw_reg, slew_hw_next;
    logic [15:0] scale_reg, scale_next;
    logic [15:0] scale_hw_reg, scale_hw_next;
    vsf_div_t div_reg, div_next;
    logic [15:0] floor_reg, floor_next;
    logic [15:0] target_reg, target_next;
    logic rsp_valid_reg, rsp_valid_next;
    logic [15:0] rsp_rdata_reg, rsp_rdata_next;
    logic rsp_refused_reg, rsp_refused_next;
    logic nota_reg, nota_next;
    logic word_vout_reg, word_vout_next;
    logic minmax_reg, minmax_next;
    logic cml_data_reg, cml_data_next;
    logic cml_cmd_reg, cml_cmd_next;
    logic alert_n_reg, alert_n_next;
    logic uvlo_meta_reg, uvlo_sync_reg, uvlo_prev_reg;
    logic [TICK_CNT_W-1:0] tick_cnt_reg, tick_cnt_next;
    logic tick_reg, tick_next;
    logic warn_set, data_set, cmd_set, scale_reload;
    logic signed [47:0] slew_check, slew_round, scale_val;

    // Slew word is valid when its decoded rate lies within the supported band
    function automatic logic slew_ok(input logic [15:0] w);
        logic signed [47:0] v;
        v = lin11_fixed(w, SLEW_CHECK_FRAC) * UV_PER_MV;
        return (v >= (SLEW_MIN_UV_PER_US <<< SLEW_CHECK_FRAC)) &&
               (v <= (SLEW_MAX_UV_PER_US <<< SLEW_CHECK_FRAC));
    endfunction

    // Scale word is valid when above zero and not above unity
    function automatic logic scale_ok(input logic [15:0] w);
        logic signed [47:0] v;
        v = lin11_fixed(w, SCALE_FRAC);
        return (v > 48'sd0) && (v <= SCALE_UNITY);
    endfunction

    always_comb
    begin
        slew_check = '0;
        slew_round = lin11_fixed(cmd_wdata, SLEW_HW_FRAC + 1) + 48'sd1;
        scale_val = '0;
        slew_next = slew_reg;
        slew_hw_next = slew_hw_reg;
        scale_next = scale_reg;
        scale_hw_next = scale_hw_reg;
        floor_next = floor_reg;
        target_next = target_reg;
        rsp_valid_next = 1'b0;
        rsp_rdata_next = rsp_rdata_reg;
        rsp_refused_next = 1'b0;
        warn_set = 1'b0;
        data_set = 1'b0;
        cmd_set = 1'b0;
        scale_reload = user_restore || (uvlo_prev_reg && !uvlo_sync_reg);
        if (cmd_valid)
        begin
            rsp_valid_next = 1'b1;
            if (cmd_code == CMD_OUTPUT_SLEW_RATE)
            begin
                rsp_rdata_next = slew_reg;
                if (cmd_write && slew_ok(cmd_wdata))
                begin
                    slew_next = cmd_wdata;
                    slew_check = slew_round >>> 1;
                    slew_hw_next = SLEW_HW_W'(slew_check);
                end
                else if (cmd_write)
                begin
                    data_set = 1'b1;
                end
            end
            else if (cmd_code == CMD_FEEDBACK_SCALE)
            begin
                rsp_rdata_next = scale_reg;
                if (cmd_write && scale_ok(cmd_wdata))
                begin
                    scale_next = cmd_wdata;
                    if (!conversion_enable)
                    begin
                        scale_hw_next = cmd_wdata;
                    end
                end
                else if (cmd_write)
                begin
                    data_set = 1'b1;
                end
            end
            else if (cmd_code == CMD_OUTPUT_FLOOR)
            begin
                rsp_rdata_next = floor_reg;
                if (cmd_write)
                begin
                    floor_next = cmd_wdata;
                    if (conversion_enable && cmd_wdata > target_reg)
                    begin
                        warn_set = 1'b1;
                        target_next = cmd_wdata;
                    end
                end
            end
            else
            begin
                cmd_set = 1'b1;
                rsp_rdata_next = '0;
            end
            rsp_refused_next = data_set || cmd_set;
        end
        if (scale_reload)
        begin
            scale_hw_next = scale_next;
        end
        if (target_req_valid)
        begin
            target_next = target_req_value;
            if (conversion_enable && target_req_value < floor_next)
            begin
                warn_set = 1'b1;
                target_next = floor_next;
            end
        end
        scale_val = lin11_fixed(scale_hw_next, SCALE_FRAC);
        if (scale_val <= SCALE_EIGHTH)
        begin
            div_next = DIV_EIGHTH;
        end
        else if (scale_val <= SCALE_QUARTER)
        begin
            div_next = DIV_QUARTER;
        end
        else if (scale_val <= SCALE_HALF)
        begin
            div_next = DIV_HALF;
        end
        else
        begin
            div_next = DIV_UNITY;
        end
        // A new event wins over a clear in the same cycle
        nota_next = warn_set || (nota_reg && !clear_status);
        word_vout_next = warn_set || (word_vout_reg && !clear_status);
        minmax_next = warn_set || (minmax_reg && !clear_status);
        cml_data_next = data_set || (cml_data_reg && !clear_status);
        cml_cmd_next = cmd_set || (cml_cmd_reg && !clear_status);
        alert_n_next = !(nota_next || word_vout_next || minmax_next || cml_data_next || cml_cmd_next);
        tick_next = (tick_cnt_reg == TICK_CNT_W'(SLEW_TICK_CYCLES - 1));
        tick_cnt_next = tick_next ? '0 : tick_cnt_reg + 1'b1;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            slew_reg <= {SLEW_EXP_RESET, SLEW_MANT_INIT};
            slew_hw_reg <= SLEW_HW_W'(SLEW_MANT_INIT);
            scale_reg <= {SCALE_EXP_RESET, SCALE_MANT_INIT};
            scale_hw_reg <= {SCALE_EXP_RESET, SCALE_MANT_INIT};
            div_reg <= DIV_UNITY;
            floor_reg <= FLOOR_INIT;
            target_reg <= TARGET_RESET;
            rsp_valid_reg <= 1'b0;
            rsp_rdata_reg <= '0;
            rsp_refused_reg <= 1'b0;
            nota_reg <= 1'b0;
            word_vout_reg <= 1'b0;
            minmax_reg <= 1'b0;
            cml_data_reg <= 1'b0;
            cml_cmd_reg <= 1'b0;
            alert_n_reg <= 1'b1;
            uvlo_meta_reg <= 1'b0;
            uvlo_sync_reg <= 1'b0;
            uvlo_prev_reg <= 1'b0;
            tick_cnt_reg <= '0;
            tick_reg <= 1'b0;
        end
        else
        begin
            slew_reg <= slew_next;
            slew_hw_reg <= slew_hw_next;
            scale_reg <= scale_next;
            scale_hw_reg <= scale_hw_next;
            div_reg <= div_next;
            floor_reg <= floor_next;
            target_reg <= target_next;
            rsp_valid_reg <= rsp_valid_next;
            rsp_rdata_reg <= rsp_rdata_next;
            rsp_refused_reg <= rsp_refused_next;
            nota_reg <= nota_next;
            word_vout_reg <= word_vout_next;
            minmax_reg <= minmax_next;
            cml_data_reg <= cml_data_next;
            cml_cmd_reg <= cml_cmd_next;
            alert_n_reg <= alert_n_next;
            uvlo_meta_reg <= analog_supply_input_uvlo;
            uvlo_sync_reg <= uvlo_meta_reg;
            uvlo_prev_reg <= uvlo_sync_reg;
            tick_cnt_reg <= tick_cnt_next;
            tick_reg <= tick_next;
        end
    end

    vsf_ramp #(
        .VOUT_W(16),
        .SLEW_W(SLEW_HW_W),
        .ACC_W(12),
        .LSB_SIXTEENTHS(VOUT_LSB_SIXTEENTHS)
    ) u_ramp (
        .core_clk(core_clk),
        .reset(reset),
        .tick(tick_reg),
        .load_now(onoff_load),
        .slew(slew_hw_reg),
        .target(target_reg),
        .vout(vout_setpoint)
    );

    assign rsp_valid = rsp_valid_reg;
    assign rsp_rdata = rsp_rdata_reg;
    assign rsp_refused = rsp_refused_reg;
    assign status_byte_none_above = nota_reg;
    assign status_word_vout = word_vout_reg;
    assign status_vout_minmax_warn = minmax_reg;
    assign status_cml_invalid_data = cml_data_reg;
    assign status_cml_invalid_cmd = cml_cmd_reg;
    assign host_alert_n = alert_n_reg;
    assign slew_applied = slew_hw_reg;
    assign scale_applied = scale_hw_reg;
    assign divider_sel = div_reg;
    assign vout_target = target_reg;
endmodule

// ### dv/vsf_host_model.sv
// Purpose: Host-side word command driver for the slew, scale and floor registers
// Assumes: One word command per pulse, answered one edge later
// Notes: Released code and data lines show the inverse of the last value
`timescale 1ns/1ps
module vsf_host_model (
    // Clock
    input wire logic core_clk,
    // Word command port
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata
);
    initial
    begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end

    // Whole word, held for the taking edge
    task automatic issue(input logic w, input logic [7:0] c, input logic [15:0] d);
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_code <= c;
        cmd_wdata <= d;
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        cmd_write <= ~w;
        cmd_code <= ~c;
        cmd_wdata <= ~d;
    endtask
endmodule

// ### dv/vsf_regs_assertions.sv
// Purpose: Port-level checks of the slew, scale and floor registers
// Assumes: Single clock domain, synchronous reset
// Notes: Divider follows the applied scale word
`timescale 1ns/1ps
module vsf_regs_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Word command port
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_rdata,
    input wire logic rsp_refused,
    // Converter and target
    input wire logic conversion_enable,
    input wire logic onoff_load,
    input wire logic user_restore,
    input wire logic analog_supply_input_uvlo,
    input wire logic target_req_valid,
    input wire logic [15:0] target_req_value,
    // Status and settings
    input wire logic status_byte_none_above,
    input wire logic status_word_vout,
    input wire logic status_vout_minmax_warn,
    input wire logic host_alert_n,
    input wire logic [vsf_pkg::SLEW_HW_W-1:0] slew_applied,
    input wire logic [15:0] scale_applied,
    input vsf_pkg::vsf_div_t divider_sel,
    input wire logic [15:0] vout_target,
    input wire logic [15:0] vout_setpoint
);
    import vsf_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_slew_wr;
        cmd_valid && cmd_write && cmd_code == CMD_OUTPUT_SLEW_RATE && cmd_wdata[15:11] == 5'h1c;
    endsequence
    sequence s_unknown;
        cmd_valid && cmd_code != CMD_OUTPUT_SLEW_RATE && cmd_code != CMD_FEEDBACK_SCALE
            && cmd_code != CMD_OUTPUT_FLOOR;
    endsequence
    sequence s_scale_direct;
        cmd_valid && cmd_write && cmd_code == CMD_FEEDBACK_SCALE && !conversion_enable
            && cmd_wdata[15:11] == 5'h19 && cmd_wdata[10:0] >= 11'h001 && cmd_wdata[10:0] <= 11'h080;
    endsequence
    sequence s_scale_held;
        (conversion_enable && !user_restore && !analog_supply_input_uvlo) [*8];
    endsequence

    a_rsp_follows: assert property (cmd_valid |=> rsp_valid)
        else $error("no response after command");
    a_no_stray: assert property (!cmd_valid |=> !rsp_valid)
        else $error("response without command");
    a_unknown_refused: assert property (s_unknown |=> rsp_refused && rsp_rdata == 16'h0000)
        else $error("unknown code not refused");
    a_slew_range: assert property (s_slew_wr ##0 (cmd_wdata[10:0] < 11'h002 || cmd_wdata[10:0] > 11'h0fe)
        |=> rsp_refused)
        else $error("out of range slew accepted");
    a_slew_applied: assert property (s_slew_wr ##0 (cmd_wdata[10:0] >= 11'h002 && cmd_wdata[10:0] <= 11'h0fe)
        |=> !rsp_refused && slew_applied == $past(cmd_wdata[7:0]))
        else $error("slew not applied");
    a_scale_direct: assert property (s_scale_direct |=> !rsp_refused && scale_applied == $past(cmd_wdata))
        else $error("scale not applied while idle");
    a_scale_held: assert property (s_scale_held |-> $stable(scale_applied))
        else $error("scale changed while converting");
    a_divider_map: assert property (scale_applied[15:11] == 5'h19 |-> divider_sel ==
        (scale_applied[10:0] <= 11'h010 ? DIV_EIGHTH : scale_applied[10:0] <= 11'h020 ? DIV_QUARTER :
        scale_applied[10:0] <= 11'h040 ? DIV_HALF : DIV_UNITY))
        else $error("divider does not match scale");
    a_idle_no_clamp: assert property (target_req_valid && !conversion_enable
        |=> vout_target == $past(target_req_value))
        else $error("target clamped while idle");
    a_floor_clamp: assert property (target_req_valid && conversion_enable
        |=> vout_target >= $past(target_req_value))
        else $error("target lowered below request");
    a_warn_flags: assert property ($rose(status_vout_minmax_warn)
        |-> status_byte_none_above && status_word_vout && !host_alert_n)
        else $error("warning flags not set together");
    a_setpoint_step: assert property (!onoff_load |=> vout_setpoint == $past(vout_setpoint)
        || vout_setpoint == $past(vout_setpoint) + 16'h0001 || vout_setpoint == $past(vout_setpoint) - 16'h0001)
        else $error("setpoint jumped while slewing");
    a_onoff_jump: assert property (onoff_load |=> vout_setpoint == $past(vout_target))
        else $error("setpoint did not jump on turn on");
endmodule

bind vsf_regs vsf_regs_checker u_chk (.*);

// ### dv/vout_slew_scale_floor_regs_bench.sv
// Purpose: Self-checking bench for the slew, scale and floor registers
// Assumes: Default parameters, 100 MHz core clock
// Notes: Responses checked against a queue of expected words
`timescale 1ns/1ps
module vout_slew_scale_floor_regs_bench;
    import vsf_pkg::*;
    logic core_clk, reset, cmd_valid, cmd_write, rsp_valid, rsp_refused;
    logic conversion_enable, onoff_load, user_restore, uvlo, target_req_valid, clear_status;
    logic st_none, st_word, st_warn, st_data, st_cmd, host_alert_n;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata, rsp_rdata, target_req_value, scale_applied, vout_target, vout_setpoint;
    logic [15:0] sh_slew, sh_scale, sh_floor;
    logic [SLEW_HW_W-1:0] slew_applied;
    logic [10:0] m;
    logic [31:0] rng;
    logic [16:0] rsp_q[$];
    logic [10:0] bm[5] = '{11'h001, 11'h002, 11'h0fe, 11'h0ff, 11'h7ff};
    logic bb[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    logic [10:0] sm[7] = '{11'h010, 11'h011, 11'h020, 11'h021, 11'h040, 11'h041, 11'h080};
    logic [1:0] sd[7] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
    vsf_div_t divider_sel;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;

    vsf_host_model u_host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
    vsf_regs u_dut (.core_clk(core_clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_refused(rsp_refused), .conversion_enable(conversion_enable), .onoff_load(onoff_load),
        .user_restore(user_restore), .analog_supply_input_uvlo(uvlo), .target_req_valid(target_req_valid),
        .target_req_value(target_req_value), .clear_status(clear_status), .status_byte_none_above(st_none),
        .status_word_vout(st_word), .status_vout_minmax_warn(st_warn), .status_cml_invalid_data(st_data),
        .status_cml_invalid_cmd(st_cmd), .host_alert_n(host_alert_n), .slew_applied(slew_applied),
        .scale_applied(scale_applied), .divider_sel(divider_sel), .vout_target(vout_target),
        .vout_setpoint(vout_setpoint));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    function automatic logic [31:0] xorshift();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d, input logic bad);
        logic [15:0] old;
        old = c == CMD_OUTPUT_SLEW_RATE ? sh_slew : c == CMD_FEEDBACK_SCALE ? sh_scale :
            c == CMD_OUTPUT_FLOOR ? sh_floor : 16'h0000;
        rsp_q.push_back({bad, old});
        if (w && !bad && c == CMD_OUTPUT_SLEW_RATE)
            sh_slew = d;
        if (w && !bad && c == CMD_FEEDBACK_SCALE)
            sh_scale = d;
        if (w && !bad && c == CMD_OUTPUT_FLOOR)
            sh_floor = d;
        u_host.issue(w, c, d);
        @(negedge core_clk);
    endtask

    task automatic tgt(input logic [15:0] v);
        @(posedge core_clk) target_req_valid <= 1'b1;
        target_req_value <= v;
        @(posedge core_clk) target_req_valid <= 1'b0;
        @(negedge core_clk);
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            fail_count++;
            print_verdict();
        end
        if (rsp_valid === 1'b1)
        begin
            if (rsp_q.size() == 0)
                check16(16'h0001, 16'h0000);
            else
            begin
                check16(rsp_rdata, rsp_q[0][15:0]);
                check16(16'(rsp_refused), 16'(rsp_q[0][16]));
                void'(rsp_q.pop_front());
            end
        end
    end

    initial
    begin
        {reset, conversion_enable, onoff_load, user_restore, uvlo, target_req_valid, clear_status} = 7'h40;
        target_req_value = 16'h0000;
        rng = 32'd95983;
        sh_slew = 16'he010;
        sh_scale = 16'hc880;
        sh_floor = 16'h0000;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        cmd(0, CMD_OUTPUT_SLEW_RATE, 16'h0000, 0);
        cmd(0, CMD_FEEDBACK_SCALE, 16'h0000, 0);
        cmd(0, CMD_OUTPUT_FLOOR, 16'h0000, 0);
        check16(16'(slew_applied), 16'h0010);
        $display("test reset_values done");
        for (int i = 0; i < 8; i++)
        begin
            m = 11'h002 + 11'(xorshift() % 253);
            cmd(1, CMD_OUTPUT_SLEW_RATE, {5'h1c, m}, 0);
            check16(16'(slew_applied), 16'(m));
        end
        for (int i = 0; i < 5; i++)
            cmd(1, CMD_OUTPUT_SLEW_RATE, {5'h1c, bm[i]}, bb[i]);
        cmd(1, CMD_OUTPUT_SLEW_RATE, 16'he810, 0);
        cmd(0, CMD_OUTPUT_SLEW_RATE, 16'h0000, 0);
        check16(16'(slew_applied), 16'h0020);
        cmd(0, 8'h30, 16'h0000, 1);
        check16({13'h0, st_data, st_cmd, host_alert_n}, 16'h0006);
        @(posedge core_clk) clear_status <= 1'b1;
        @(posedge core_clk) clear_status <= 1'b0;
        @(negedge core_clk);
        check16({14'h0, st_cmd, host_alert_n}, 16'h0001);
        $display("test slew_rate done");
        for (int i = 0; i < 7; i++)
        begin
            cmd(1, CMD_FEEDBACK_SCALE, {5'h19, sm[i]}, 0);
            check16(16'(divider_sel), {14'h0, sd[i]});
        end
        for (int i = 0; i < 3; i++)
            cmd(1, CMD_FEEDBACK_SCALE, {5'h19, bm[i * 2] - 11'h001}, 1);
        @(posedge core_clk) conversion_enable <= 1'b1;
        cmd(1, CMD_FEEDBACK_SCALE, 16'hc810, 0);
        check16(scale_applied, 16'hc880);
        @(posedge core_clk) user_restore <= 1'b1;
        @(posedge core_clk) user_restore <= 1'b0;
        repeat (2) @(negedge core_clk);
        check16(scale_applied, 16'hc810);
        cmd(1, CMD_FEEDBACK_SCALE, 16'hc820, 0);
        @(posedge core_clk) uvlo <= 1'b1;
        repeat (3) @(posedge core_clk);
        uvlo <= 1'b0;
        repeat (8) @(negedge core_clk);
        check16(scale_applied, 16'hc820);
        $display("test scale_factor done");
        tgt(16'd200);
        @(posedge core_clk) onoff_load <= 1'b1;
        @(posedge core_clk) onoff_load <= 1'b0;
        @(negedge core_clk);
        check16(vout_setpoint, 16'd200);
        cmd(1, CMD_OUTPUT_FLOOR, 16'd100, 0);
        tgt(16'd50);
        check16({12'h0, st_none, st_word, st_warn, host_alert_n}, 16'h000e);
        check16(vout_target, 16'd100);
        @(posedge core_clk) clear_status <= 1'b1;
        @(posedge core_clk) clear_status <= 1'b0;
        cmd(1, CMD_OUTPUT_FLOOR, 16'd300, 0);
        check16(16'(st_warn), 16'h0001);
        check16(vout_target, 16'd300);
        repeat (1000) @(negedge core_clk);
        check16(16'(vout_setpoint > 16'd195 && vout_setpoint < 16'd230), 16'h0001);
        @(posedge core_clk) onoff_load <= 1'b1;
        @(posedge core_clk) onoff_load <= 1'b0;
        @(negedge core_clk);
        check16(vout_setpoint, 16'd300);
        @(posedge core_clk) conversion_enable <= 1'b0;
        tgt(16'd20);
        check16(vout_target, 16'd20);
        $display("test output_floor done");
        print_verdict();
    end
endmodule
